// file: dmapb_map.svh
// register offsets, field positions and reset values of the channel
`ifndef DMAPB_MAP_SVH
`define DMAPB_MAP_SVH
`define DMAPB_OFS_CTRL   8'h00
`define DMAPB_OFS_EVT    8'h04
`define DMAPB_OFS_FLAGS  8'h08
`define DMAPB_OFS_SSA    8'h0C
`define DMAPB_OFS_DSA    8'h10
`define DMAPB_OFS_SSIZ   8'h14
`define DMAPB_OFS_DSIZ   8'h18
`define DMAPB_OFS_CSIZ   8'h1C
`define DMAPB_OFS_MATCH  8'h20
`define DMAPB_OFS_SIDX   8'h24
`define DMAPB_OFS_DIDX   8'h28
`define DMAPB_OFS_CIDX   8'h2C
`define DMAPB_BIT_ON     7
`define DMAPB_BIT_AUTO   4
`define DMAPB_BIT_FORCE  7
`define DMAPB_BIT_ABORT  6
`define DMAPB_BIT_MATCH  5
`define DMAPB_BIT_AERR   0
`define DMAPB_BIT_ABRT   1
`define DMAPB_BIT_BDONE  3
`define DMAPB_RST_BYTE   8'h00
`define DMAPB_RST_WORD   32'h0000_0000
`define DMAPB_REGION_MAX 9'h100
`define DMAPB_FIFO_DEPTH 8
`define DMAPB_BYTE_W     8
`endif

// file: dmapb_pkg.sv
// types shared by the channel
package dmapb_pkg;
  typedef enum logic [2:0] {
    DMAPB_IDLE = 3'b001,
    DMAPB_RD   = 3'b010,
    DMAPB_WR   = 3'b100
  } dmapb_state_t;
endpackage

// file: dmapb_channel.sv
// byte fifo and basic-mode dma channel with pattern stop
`timescale 1ns/1ps
`default_nettype none
`include "dmapb_map.svh"

module dmapb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end else begin
        if (push) wp_q <= nxt(wp_q);
        if (pop) rp_q <= nxt(rp_q);
        cnt_q <= (AW+1)'(cnt_q + push - pop);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push && !flush) mem_q[wp_q] <= in_data;
  end
endmodule // dmapb_fifo

////////////////////////////////////////////////////////////////////////////
// What this block does
// - a block never moves more than 256 bytes
// - source and destination indices wrap at their region sizes
// - block ends when bytes moved equal larger of the two sizes
// - each trigger moves one cell, cut to what the block has left
// - region size zero means 256 bytes
// - pattern stop works only while its enable bit 5 is set
// - every written byte is compared with the match byte; hit ends it
// - a hit acts as block done: flag bit 3, enable off unless auto
// - writing one to force start bit 7 starts a cell on an enabled channel
// - flags: address error bit 0, abort bit 1, block done bit 3
// - start addresses go out on the bus as physical, untranslated
// - cell count zero means 256 bytes, otherwise N bytes
// - transactions are single byte lanes: up to 8 reads fill the fifo, then writes drain it
// - a pattern hit returns all three indices to zero
module dmapb_channel (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        trig_evt,
  output logic             m_valid,
  output logic             m_write,
  output logic      [31:0] m_addr,
  output logic      [3:0]  m_be,
  output logic      [31:0] m_wdata,
  input  wire logic        m_ready,
  input  wire logic [31:0] m_rdata,
  input  wire logic        m_err,
  output logic             busy
);
  dmapb_pkg::dmapb_state_t st_q;
  logic        channel_on;
  logic        auto_reenable;
  logic        match_stop_on;
  logic [3:0]  channel_irq_flags;
  logic [31:0] src_start_addr;
  logic [31:0] dst_start_addr;
  logic [7:0]  src_region_size;
  logic [7:0]  dst_region_size;
  logic [7:0]  cell_byte_count;
  logic [7:0]  match_byte;
  logic [7:0]  src_byte_index;
  logic [7:0]  dst_byte_index;
  logic [7:0]  cell_index;
  logic [8:0]  blk_cnt_q;
  logic [8:0]  rd_left_q;
  logic [8:0]  wr_left_q;
  logic        pend_q;
  logic        abort_q;
  logic [31:0] prdata_q;
  logic        wr_acc;
  logic        rd_setup;
  logic        hs;
  logic        rd_hs;
  logic        wr_hs;
  logic        bus_err;
  logic        match_hit;
  logic        blk_end;
  logic        finish;
  logic        abort_go;
  logic        stop;
  logic        start;
  logic        known;
  logic [8:0]  blk_size;
  logic [8:0]  cell_n;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [7:0]  f_out;
  logic [7:0]  rd_byte;

  // zero stands for a full region
  function automatic logic [8:0] size9(input logic [7:0] v);
    size9 = (v == 8'h00) ? `DMAPB_REGION_MAX : {1'b0, v};
  endfunction

  function automatic logic [7:0] wrap_inc(input logic [7:0] i,
                                          input logic [7:0] sz);
    logic [8:0] n;
    n = {1'b0, i} + 9'h001;
    wrap_inc = (n == size9(sz)) ? 8'h00 : n[7:0];
  endfunction

  function automatic logic [3:0] lane(input logic [1:0] a);
    lane = 4'h1 << a;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // apb slave
  assign pready   = ce;
  assign wr_acc   = psel && penable && pwrite && ce;
  assign rd_setup = psel && !penable && !pwrite && ce;
  assign prdata   = prdata_q;
  assign known    = (paddr[1:0] == 2'b00) && (paddr <= `DMAPB_OFS_CIDX);
  assign pslverr  = psel && penable && !known;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `DMAPB_RST_WORD;
    end else if (rd_setup) begin
      unique case (paddr)
        `DMAPB_OFS_CTRL:  prdata_q <= (32'(channel_on) << `DMAPB_BIT_ON)
                                      | (32'(auto_reenable)
                                         << `DMAPB_BIT_AUTO);
        `DMAPB_OFS_EVT:   prdata_q <= 32'(match_stop_on)
                                      << `DMAPB_BIT_MATCH;
        `DMAPB_OFS_FLAGS: prdata_q <= {28'h0000000, channel_irq_flags};
        `DMAPB_OFS_SSA:   prdata_q <= src_start_addr;
        `DMAPB_OFS_DSA:   prdata_q <= dst_start_addr;
        `DMAPB_OFS_SSIZ:  prdata_q <= {24'h000000, src_region_size};
        `DMAPB_OFS_DSIZ:  prdata_q <= {24'h000000, dst_region_size};
        `DMAPB_OFS_CSIZ:  prdata_q <= {24'h000000, cell_byte_count};
        `DMAPB_OFS_MATCH: prdata_q <= {24'h000000, match_byte};
        `DMAPB_OFS_SIDX:  prdata_q <= {24'h000000, src_byte_index};
        `DMAPB_OFS_DIDX:  prdata_q <= {24'h000000, dst_byte_index};
        `DMAPB_OFS_CIDX:  prdata_q <= {24'h000000, cell_index};
        default:          prdata_q <= `DMAPB_RST_WORD;
      endcase
    end
  end

  // plain configuration words; addresses stay physical
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_start_addr  <= `DMAPB_RST_WORD;
      dst_start_addr  <= `DMAPB_RST_WORD;
      src_region_size <= `DMAPB_RST_BYTE;
      dst_region_size <= `DMAPB_RST_BYTE;
      cell_byte_count <= `DMAPB_RST_BYTE;
      match_byte      <= `DMAPB_RST_BYTE;
      auto_reenable   <= 1'b0;
      match_stop_on   <= 1'b0;
    end else if (wr_acc && pstrb[0]) begin
      unique case (paddr)
        `DMAPB_OFS_SSA:   src_start_addr  <= pwdata;
        `DMAPB_OFS_DSA:   dst_start_addr  <= pwdata;
        `DMAPB_OFS_SSIZ:  src_region_size <= pwdata[7:0];
        `DMAPB_OFS_DSIZ:  dst_region_size <= pwdata[7:0];
        `DMAPB_OFS_CSIZ:  cell_byte_count <= pwdata[7:0];
        `DMAPB_OFS_MATCH: match_byte      <= pwdata[7:0];
        `DMAPB_OFS_CTRL:  auto_reenable   <= pwdata[`DMAPB_BIT_AUTO];
        `DMAPB_OFS_EVT:   match_stop_on   <= pwdata[`DMAPB_BIT_MATCH];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // termination events
  assign hs       = m_valid && m_ready && ce;
  assign rd_hs    = hs && (st_q == dmapb_pkg::DMAPB_RD);
  assign wr_hs    = hs && (st_q == dmapb_pkg::DMAPB_WR);
  assign bus_err  = hs && m_err;
  assign match_hit = wr_hs && !m_err && match_stop_on
                     && (f_out == match_byte);
  // larger region sets the block length, never above 256
  assign blk_size = (size9(src_region_size) > size9(dst_region_size))
                    ? size9(src_region_size)
                    : size9(dst_region_size);
  assign blk_end  = wr_hs && !m_err
                    && (9'(blk_cnt_q + 9'h001) == blk_size);
  assign finish   = match_hit || blk_end;
  // abort waits for the transaction under way to complete
  assign abort_go = abort_q && ce && (!m_valid || m_ready);
  assign stop     = finish || bus_err || abort_go;
  assign start    = ce && (st_q == dmapb_pkg::DMAPB_IDLE) && channel_on
                    && pend_q && !abort_q;
  assign cell_n   = (size9(cell_byte_count) > 9'(blk_size - blk_cnt_q))
                    ? 9'(blk_size - blk_cnt_q)
                    : size9(cell_byte_count);

  // enable bit: software sets, completions clear unless auto
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on <= 1'b0;
    end else if (ce) begin
      if ((finish && !auto_reenable) || bus_err || abort_go)
        channel_on <= 1'b0;
      else if (wr_acc && pstrb[0] && paddr == `DMAPB_OFS_CTRL)
        channel_on <= pwdata[`DMAPB_BIT_ON];
    end
  end

  // triggers are remembered while a cell runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q  <= 1'b0;
      abort_q <= 1'b0;
    end else if (ce) begin
      // an off channel drops events so nothing fires on a later enable
      if (channel_on && (trig_evt || (wr_acc && pstrb[0]
          && paddr == `DMAPB_OFS_EVT && pwdata[`DMAPB_BIT_FORCE])))
        pend_q <= 1'b1;
      else if (start || abort_go || !channel_on)
        pend_q <= 1'b0;
      if (wr_acc && pstrb[0] && paddr == `DMAPB_OFS_EVT
          && pwdata[`DMAPB_BIT_ABORT])
        abort_q <= 1'b1;
      else if (abort_go)
        abort_q <= 1'b0;
    end
  end

  // sticky flags, write one to clear, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq_flags <= 4'h0;
    end else if (ce) begin
      for (int b = 0; b < 4; b++) begin
        if ((b == `DMAPB_BIT_AERR && bus_err)
            || (b == `DMAPB_BIT_ABRT && abort_go)
            || (b == `DMAPB_BIT_BDONE && finish))
          channel_irq_flags[b] <= 1'b1;
        else if (wr_acc && pstrb[0] && paddr == `DMAPB_OFS_FLAGS
                 && pwdata[b])
          channel_irq_flags[b] <= 1'b0;
      end
      channel_irq_flags[2] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= dmapb_pkg::DMAPB_IDLE;
    end else if (ce) begin
      unique case (st_q)
        dmapb_pkg::DMAPB_IDLE: begin
          if (start) st_q <= dmapb_pkg::DMAPB_RD;
        end
        dmapb_pkg::DMAPB_RD: begin
          if (stop) st_q <= dmapb_pkg::DMAPB_IDLE;
          else if (!m_valid) st_q <= dmapb_pkg::DMAPB_WR;
        end
        dmapb_pkg::DMAPB_WR: begin
          if (stop || (wr_hs && wr_left_q == 9'h001))
            st_q <= dmapb_pkg::DMAPB_IDLE;
          else if (!f_out_valid) st_q <= dmapb_pkg::DMAPB_RD;
        end
      endcase
    end
  end

  // indices and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_byte_index <= `DMAPB_RST_BYTE;
      dst_byte_index <= `DMAPB_RST_BYTE;
      cell_index     <= `DMAPB_RST_BYTE;
      blk_cnt_q      <= 9'h000;
      rd_left_q      <= 9'h000;
      wr_left_q      <= 9'h000;
    end else if (ce) begin
      if (finish || abort_go) begin
        src_byte_index <= `DMAPB_RST_BYTE;
        dst_byte_index <= `DMAPB_RST_BYTE;
        cell_index     <= `DMAPB_RST_BYTE;
        blk_cnt_q      <= 9'h000;
        rd_left_q      <= 9'h000;
        wr_left_q      <= 9'h000;
      end else begin
        if (start) begin
          rd_left_q  <= cell_n;
          wr_left_q  <= cell_n;
          cell_index <= `DMAPB_RST_BYTE;
        end
        if (rd_hs && !m_err) begin
          rd_left_q      <= 9'(rd_left_q - 9'h001);
          src_byte_index <= wrap_inc(src_byte_index, src_region_size);
        end
        if (wr_hs && !m_err) begin
          wr_left_q      <= 9'(wr_left_q - 9'h001);
          blk_cnt_q      <= 9'(blk_cnt_q + 9'h001);
          cell_index     <= 8'(cell_index + 8'h01);
          dst_byte_index <= wrap_inc(dst_byte_index, dst_region_size);
        end
        if (wr_acc && pstrb[0] && paddr == `DMAPB_OFS_SSA)
          src_byte_index <= `DMAPB_RST_BYTE;
        if (wr_acc && pstrb[0] && paddr == `DMAPB_OFS_DSA)
          dst_byte_index <= `DMAPB_RST_BYTE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus master: one byte lane per transaction keeps alignment trivial
  assign rd_byte = m_rdata[{m_addr[1:0], 3'b000} +: 8];
  assign m_write = (st_q == dmapb_pkg::DMAPB_WR);
  assign m_valid = ((st_q == dmapb_pkg::DMAPB_RD) && rd_left_q != 9'h000
                    && f_in_ready)
                   || ((st_q == dmapb_pkg::DMAPB_WR) && f_out_valid
                       && wr_left_q != 9'h000);
  assign m_addr  = m_write ? 32'(dst_start_addr + dst_byte_index)
                           : 32'(src_start_addr + src_byte_index);
  assign m_be    = lane(m_addr[1:0]);
  assign m_wdata = {4{f_out}};
  assign busy    = (st_q != dmapb_pkg::DMAPB_IDLE);

  // source bytes wait here; a full fifo turns the sequencer to writing
  dmapb_fifo #(
    .W (`DMAPB_BYTE_W),
    .D (`DMAPB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .ce        (ce),
    .flush     (stop || start),
    .in_valid  (rd_hs && !m_err),
    .in_ready  (f_in_ready),
    .in_data   (rd_byte),
    .out_valid (f_out_valid),
    .out_ready (wr_hs && !m_err),
    .out_data  (f_out)
  );
endmodule // dmapb_channel
`default_nettype wire

// file: dmapb_monitor.sv
// port checker for the dma channel
`timescale 1ns/1ps
`default_nettype none
module dmapb_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        m_valid,
  input wire logic        m_write,
  input wire logic [31:0] m_addr,
  input wire logic [3:0]  m_be,
  input wire logic [31:0] m_wdata,
  input wire logic        m_ready,
  input wire logic        m_err,
  input wire logic        busy
);
  // bytes read but not yet written; cleared when idle since flush drops them
  logic [4:0] owed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) owed_q <= 5'h00;
    else if (!busy) owed_q <= 5'h00;
    else if (m_valid && m_ready && !m_err)
      owed_q <= m_write ? owed_q - 5'h01 : owed_q + 5'h01;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_ok; m_valid && m_ready && !m_write && !m_err; endsequence
  sequence s_err; m_valid && m_ready && m_err; endsequence
  ////////////////////////////////////////////////////////////
  property p_hold;
    m_valid && !m_ready |=> m_valid && $stable(m_addr) && $stable(m_write);
  endproperty
  property p_lane; m_valid |-> m_be == (4'h1 << m_addr[1:0]); endproperty
  property p_rep; m_valid && m_write |-> m_wdata == {4{m_wdata[7:0]}};
  endproperty
  property p_pair; m_valid && m_write |-> owed_q != 5'h00; endproperty
  property p_depth; owed_q <= 5'h08; endproperty
  property p_wr_follows;
    s_rd_ok |-> ##[1:300] ((m_valid && m_write) || !busy);
  endproperty
  property p_err; s_err |=> !busy [*2]; endproperty
  property p_slverr; psel && penable && ce |->
    pslverr == (paddr > 8'h2C || paddr[1:0] != 2'b00); endproperty
  property p_prdata; !(psel && !penable) |=> $stable(prdata); endproperty
  property p_busy; m_valid |-> busy; endproperty
  a_hold: assert property (p_hold)
    else $error("request moved");
  a_lane: assert property (p_lane)
    else $error("bad lane");
  a_rep: assert property (p_rep)
    else $error("bad wdata");
  a_pair: assert property (p_pair)
    else $error("write unread");
  a_depth: assert property (p_depth)
    else $error("fifo over");
  a_wr_follows: assert property (p_wr_follows)
    else $error("no write");
  a_err: assert property (p_err)
    else $error("err not idle");
  a_slverr: assert property (p_slverr)
    else $error("bad slverr");
  a_prdata: assert property (p_prdata)
    else $error("prdata moved");
  a_busy: assert property (p_busy)
    else $error("req idle");
endmodule // dmapb_monitor
bind dmapb_channel dmapb_monitor u_mon (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .pslverr, .prdata, .m_valid, .m_write,
  .m_addr, .m_be, .m_wdata, .m_ready, .m_err, .busy);
`default_nettype wire

// file: dmapb_mem_model.sv
// bus memory model answering the channel's master port
`timescale 1ns/1ps
`default_nettype none
module dmapb_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        m_valid,
  input  wire logic        m_write,
  input  wire logic [31:0] m_addr,
  input  wire logic [31:0] m_wdata,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic [31:0] err_addr,
  output logic             m_ready,
  output logic      [31:0] m_rdata,
  output logic             m_err
);
  logic [3:0] cnt_q;
  logic [7:0] dst [logic [31:0]];
  int         n_wr = 0;
  assign m_ready = m_valid && cnt_q == wait_cyc;
  assign m_err   = m_ready && m_addr == err_addr;
  // inverted off the answer edge so stale data is never reused
  assign m_rdata = m_ready ? {4{m_addr[7:0] + 8'h11}}
                           : ~{4{m_addr[7:0] + 8'h11}};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 4'h0;
    else cnt_q <= (m_valid && !m_ready) ? cnt_q + 4'h1 : 4'h0;
  end
  always @(posedge pclk) begin
    if (m_ready && m_write && !m_err) begin
      dst[m_addr] = m_wdata[7:0];
      n_wr++;
    end
  end
endmodule // dmapb_mem_model
`default_nettype wire

// file: tb_dma_channel_basic_pattern_transfer.sv
// self-checking bench for the dma channel
`timescale 1ns/1ps
`default_nettype none
`include "dmapb_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_dma_channel_basic_pattern_transfer;
  logic        pclk, presetn, psel, penable, pwrite, trig_evt;
  logic        pready, pslverr, m_valid, m_write, m_ready, m_err, busy, er;
  logic [7:0]  paddr;
  logic [3:0]  m_be, wait_cyc;
  logic [31:0] pwdata, prdata, m_addr, m_wdata, m_rdata, rd, err_addr;
  int          miscompares = 0, n_tests = 0, cyc = 0, n0;
  localparam logic [31:0] ON = 32'h1 << `DMAPB_BIT_ON;
  localparam logic [31:0] FRC = 32'h1 << `DMAPB_BIT_FORCE;
  dmapb_channel uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hF), .pready, .pslverr, .prdata, .trig_evt,
    .m_valid, .m_write, .m_addr, .m_be, .m_wdata, .m_ready, .m_rdata,
    .m_err, .busy);
  dmapb_mem_model mem (.pclk, .presetn, .m_valid, .m_write, .m_addr,
    .m_wdata, .wait_cyc, .err_addr, .m_ready, .m_rdata, .m_err);
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] sb(input logic [31:0] a);
    return a[7:0] + 8'h11;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task settle;
    repeat (4) @(posedge pclk);
    repeat (5000) if (busy !== 1'b0) @(posedge pclk);
  endtask
  task pulse;
    @(posedge pclk) trig_evt <= 1;
    @(posedge pclk) trig_evt <= 0;
  endtask
  task setup(input logic [31:0] s, d, ss, ds, cs);
    wr(`DMAPB_OFS_SSA, s); wr(`DMAPB_OFS_DSA, d);
    wr(`DMAPB_OFS_SSIZ, ss); wr(`DMAPB_OFS_DSIZ, ds);
    wr(`DMAPB_OFS_CSIZ, cs); wr(`DMAPB_OFS_FLAGS, 32'hB);
    n0 = mem.n_wr;
  endtask
  task dst_chk(input logic [31:0] d, s, input int ss, n);
    for (int i = 0; i < n; i++)
      `CHK("dst", sb(s + i % ss), mem.dst[d + i])
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    rdchk("ctrl", `DMAPB_OFS_CTRL, 32'h0);
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h0);
    wr(`DMAPB_OFS_SIDX, 32'hFF);
    rdchk("sidx", `DMAPB_OFS_SIDX, 32'h0);
    wr(`DMAPB_OFS_MATCH, 32'hA5);
    rdchk("match", `DMAPB_OFS_MATCH, 32'hA5);
    apb(0, 8'h30, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0, rd)
  endtask
  task t_basic;
    wait_cyc <= 4'h2;
    setup(32'h1000, 32'h2000, 3, 5, 0);
    wr(`DMAPB_OFS_CTRL, ON);
    wr(`DMAPB_OFS_EVT, FRC);
    settle();
    `CHK("nwr", 5, mem.n_wr - n0)
    dst_chk(32'h2000, 32'h1000, 3, 5);
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h8);
    rdchk("ctrl", `DMAPB_OFS_CTRL, 32'h0);
  endtask
  task t_cells;
    wait_cyc <= 4'h1;
    setup(32'h4000, 32'h5000, 0, 0, 16);
    wr(`DMAPB_OFS_CTRL, ON);
    pulse();
    repeat (4) @(posedge pclk);
    pulse();
    settle();
    settle();
    `CHK("nwr", 32, mem.n_wr - n0)
    rdchk("didx", `DMAPB_OFS_DIDX, 32'h20);
    wr(`DMAPB_OFS_CSIZ, 32'h0);
    pulse();
    settle();
    `CHK("nwr", 256, mem.n_wr - n0)
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h8);
    dst_chk(32'h5000, 32'h4000, 256, 256);
  endtask
  task t_pattern;
    wait_cyc <= 4'h0;
    setup(32'h3000, 32'h6000, 8, 8, 8);
    wr(`DMAPB_OFS_MATCH, 32'h13);
    wr(`DMAPB_OFS_CTRL, ON | 32'h10);
    wr(`DMAPB_OFS_EVT, 32'h20 | FRC);
    settle();
    `CHK("nwr", 3, mem.n_wr - n0)
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h8);
    rdchk("ctrl", `DMAPB_OFS_CTRL, ON | 32'h10);
    rdchk("sidx", `DMAPB_OFS_SIDX, 32'h0);
    rdchk("cidx", `DMAPB_OFS_CIDX, 32'h0);
    wr(`DMAPB_OFS_FLAGS, 32'h8);
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h0);
    wr(`DMAPB_OFS_EVT, FRC);
    settle();
    `CHK("nwr", 11, mem.n_wr - n0)
    dst_chk(32'h6000, 32'h3000, 8, 8);
    wr(`DMAPB_OFS_CTRL, 32'h0);
  endtask
  task t_err_abort;
    err_addr <= 32'h7001;
    setup(32'h7000, 32'h8000, 4, 4, 4);
    wr(`DMAPB_OFS_CTRL, ON);
    wr(`DMAPB_OFS_EVT, FRC);
    settle();
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h1);
    rdchk("ctrl", `DMAPB_OFS_CTRL, 32'h0);
    `CHK("nwr", 0, mem.n_wr - n0)
    wr(`DMAPB_OFS_FLAGS, 32'h1);
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h0);
    err_addr <= 32'hFFFF_FFFF;
    wait_cyc <= 4'h8;
    wr(`DMAPB_OFS_EVT, FRC);
    settle();
    `CHK("nwr", 0, mem.n_wr - n0)
    // a force given while off must not fire later on enable
    wr(`DMAPB_OFS_CTRL, ON);
    repeat (3) @(posedge pclk);
    `CHK("busy", 1'b0, busy)
    wr(`DMAPB_OFS_EVT, FRC);
    wr(`DMAPB_OFS_EVT, 32'h40);
    settle();
    rdchk("flags", `DMAPB_OFS_FLAGS, 32'h2);
    rdchk("ctrl", `DMAPB_OFS_CTRL, 32'h0);
  endtask
  task summarize;
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; trig_evt = 0; wait_cyc = 4'h0; err_addr = 32'hFFFF_FFFF;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_basic();
    t_cells();
    t_pattern();
    t_err_abort();
    summarize();
  end
endmodule // tb_dma_channel_basic_pattern_transfer
`default_nettype wire
